// [core/sne_pkg.sv]
// Constants and types for the serial NOR erase and suspend sequencer
package sne_pkg;
  localparam int CLK_MHZ = 250;
  // Array operation times, microseconds
  localparam int SUBSECTOR_ERASE_TIME_US = 400;
  localparam int SECTOR_ERASE_TIME_US = 1000;
  localparam int DIE_ERASE_TIME_US = 4000;
  localparam int PROGRAM_TIME_US = 120;
  localparam int SUBSECTOR_ERASE_CYC = SUBSECTOR_ERASE_TIME_US * CLK_MHZ;
  localparam int SECTOR_ERASE_CYC = SECTOR_ERASE_TIME_US * CLK_MHZ;
  localparam int DIE_ERASE_CYC = DIE_ERASE_TIME_US * CLK_MHZ;
  localparam int PROGRAM_CYC = PROGRAM_TIME_US * CLK_MHZ;
  // Suspend latency, longest time, rounds down
  localparam int SUSP_LAT_NS = 2000;
  localparam int SUSP_LAT_CYC = (SUSP_LAT_NS * CLK_MHZ) / 1000;
  // Command codes
  localparam logic [7:0] CMD_WREN = 8'h06;
  localparam logic [7:0] CMD_WRDI = 8'h04;
  localparam logic [7:0] CMD_SUB_ERASE = 8'h20;
  localparam logic [7:0] CMD_SEC_ERASE = 8'hd8;
  localparam logic [7:0] CMD_DIE_ERASE = 8'hc4;
  localparam logic [7:0] CMD_PROG = 8'h02;
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_SUSPEND = 8'h75;
  localparam logic [7:0] CMD_RESUME = 8'h7a;
  // Frame lengths in bits
  localparam logic [5:0] CNT_CMD = 6'h08;
  localparam logic [5:0] CNT_ADDR = 6'h20;
  localparam logic [5:0] CNT_PROG = 6'h28;
  localparam logic [5:0] CNT_MAX = 6'h3f;
  // Flag status bit positions and reset value
  localparam int FSR_READY = 7;
  localparam int FSR_ER_SUSP = 6;
  localparam int FSR_ER_ERR = 5;
  localparam int FSR_PG_ERR = 4;
  localparam int FSR_PG_SUSP = 2;
  localparam int FSR_PROT = 1;
  localparam logic [7:0] FSR_RST = 8'h80;
  localparam logic [7:0] FSR_W1C = 8'h32;
  localparam logic [7:0] ERASE_FILL = 8'hff;
  // Register byte offsets
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_FSR = 4'h4;
  localparam logic [3:0] REG_LOCK = 4'h8;
  localparam logic [31:0] LOCK_RST = 32'h0;
  typedef enum logic [1:0] {
    SNE_K_SUB, SNE_K_SEC, SNE_K_DIE, SNE_K_PROG
  } sne_kind_t;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_SUSP} sne_state_t;
endpackage : sne_pkg

// [core/sne_sync3.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module sne_sync3 (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Pin and synchronised level
  input wire logic pin,
  output logic level
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      s3_ff <= 1'b1;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Change only once the last two stages agree
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      level_ff <= 1'b1;
    end else if (s2_ff == s3_ff) begin
      level_ff <= s3_ff;
    end
  end

  assign level = level_ff;
endmodule : sne_sync3
`default_nettype wire

// [core/sne_erase_seq.sv]
// Erase, program and suspend/resume sequencer with Avalon-MM registers
//
// Function
// - Erase writes FFh over addressed region
// - Erase ignored without write enable latch
// - Partial-byte or unterminated frames are discarded
// - Erase duration chosen by command kind
// - Protected subsector erase refused, flags 1,5
// - Die erase refused if any lock
// - Busy shows wip 1, ready 0
// - Latch cleared at end of erase
// - Failed erase sets erase error bit
// - Address bits sampled on rising clock
// - Suspend 75h halts running operation
// - Suspend sets bit 2 or 6
// - Bit 7 set after suspend latency
// - Near completion finishes, clears suspend bit
// - Flag status resets to 80h
// - One nesting level, suspended program resumes before suspended erase
// - Reads of suspended page flagged undefined
// - Reads in suspended erase sector undefined
// - Program into erase-suspended sector refused
// - Resumed erase skips lock recheck
// - Resume 7Ah restarts only when suspended
`timescale 1ns/1ps
`default_nettype none
module sne_erase_seq #(
  parameter int unsigned SSE_CYC = sne_pkg::SUBSECTOR_ERASE_CYC,
  parameter int unsigned SE_CYC = sne_pkg::SECTOR_ERASE_CYC,
  parameter int unsigned BE_CYC = sne_pkg::DIE_ERASE_CYC,
  parameter int unsigned PP_CYC = sne_pkg::PROGRAM_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Serial command pins
  input wire logic sck,
  input wire logic select_n,
  input wire logic serial_data_lines,
  // Array side
  input wire logic array_verify_ok,
  output logic arr_go,
  output logic [1:0] arr_kind,
  output logic [23:0] arr_addr,
  output logic [7:0] arr_data,
  output logic rd_undefined,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  localparam logic [15:0] LAT = 16'(sne_pkg::SUSP_LAT_CYC);
  localparam int LAT_A = sne_pkg::SUSP_LAT_CYC + 2;

  logic sck_s;
  logic sel_n_s;
  logic sdi_s;
  logic sck_q_ff;
  logic sel_q_ff;
  logic [39:0] shift_ff;
  logic [5:0] cnt_ff;
  logic ex;
  logic [7:0] cmd;
  logic [23:0] addr;
  logic [7:0] pdata;

  sne_sync3 u_sync_sck (.core_clk(core_clk), .nrst(nrst), .pin(sck),
    .level(sck_s));
  sne_sync3 u_sync_sel (.core_clk(core_clk), .nrst(nrst), .pin(select_n),
    .level(sel_n_s));
  sne_sync3 u_sync_sdi (.core_clk(core_clk), .nrst(nrst),
    .pin(serial_data_lines), .level(sdi_s));

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      // Matches the synchroniser reset level, so no false edge
      sck_q_ff <= 1'b1;
      sel_q_ff <= 1'b1;
    end else begin
      sck_q_ff <= sck_s;
      sel_q_ff <= sel_n_s;
    end
  end

  // Shift on rising serial clock while selected
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      shift_ff <= 40'h0;
      cnt_ff <= 6'h0;
    end else if (sel_n_s) begin
      cnt_ff <= 6'h0;
    end else if (sck_s && !sck_q_ff) begin
      shift_ff <= {shift_ff[38:0], sdi_s};
      if (cnt_ff != sne_pkg::CNT_MAX) begin
        cnt_ff <= cnt_ff + 6'h01;
      end
    end
  end

  // Frame ends on select rising; decode by bit count
  assign ex = sel_n_s && !sel_q_ff;
  always_comb begin
    cmd = 8'h0;
    addr = 24'h0;
    pdata = 8'h0;
    if (cnt_ff == sne_pkg::CNT_CMD) begin
      cmd = shift_ff[7:0];
    end else if (cnt_ff == sne_pkg::CNT_ADDR) begin
      cmd = shift_ff[31:24];
      addr = shift_ff[23:0];
    end else if (cnt_ff == sne_pkg::CNT_PROG) begin
      cmd = shift_ff[39:32];
      addr = shift_ff[31:8];
      pdata = shift_ff[7:0];
    end
  end

  // Sequencer state
  sne_pkg::sne_state_t st_ff;
  logic run_er_ff;
  logic [31:0] rem_ff;
  logic [15:0] lat_ff;
  logic [1:0] cur_kind_ff;
  logic [23:0] cur_addr_ff;
  logic [7:0] cur_data_ff;
  logic er_susp_ff;
  logic pg_susp_ff;
  logic [31:0] er_rem_ff;
  logic [31:0] pg_rem_ff;
  logic [1:0] er_kind_ff;
  logic [23:0] er_addr_ff;
  logic [23:0] pg_addr_ff;
  logic [7:0] pg_data_ff;
  logic wel_ff;
  logic wip_ff;
  logic [7:0] fsr_ff;
  logic [31:0] lock_ff;
  logic waitreq_ff;

  logic is_erase;
  logic is_prog;
  logic [1:0] kind;
  logic locked;
  logic done_ev;
  logic fsr_clr;

  // Unframed commands with wrong bit counts decode as 00h and drop
  assign is_erase = ex && cnt_ff == sne_pkg::CNT_ADDR
    && (cmd == sne_pkg::CMD_SUB_ERASE || cmd == sne_pkg::CMD_SEC_ERASE
    || cmd == sne_pkg::CMD_DIE_ERASE);
  assign is_prog = ex && cnt_ff == sne_pkg::CNT_PROG
    && cmd == sne_pkg::CMD_PROG;
  assign kind = is_prog ? sne_pkg::SNE_K_PROG
    : cmd == sne_pkg::CMD_SUB_ERASE ? sne_pkg::SNE_K_SUB
    : cmd == sne_pkg::CMD_SEC_ERASE ? sne_pkg::SNE_K_SEC
    : sne_pkg::SNE_K_DIE;
  assign locked = (kind == sne_pkg::SNE_K_DIE) ? |lock_ff
    : lock_ff[addr[20:16]];
  assign done_ev = st_ff != sne_pkg::ST_IDLE && rem_ff == 32'h1;
  assign fsr_clr = avs_write && !waitreq_ff
    && avs_address == sne_pkg::REG_FSR && avs_byteenable[0];

  function automatic logic [31:0] dur(input logic [1:0] k);
    logic [31:0] d;
    d = 32'(PP_CYC);
    if (k == sne_pkg::SNE_K_SUB) d = 32'(SSE_CYC);
    else if (k == sne_pkg::SNE_K_SEC) d = 32'(SE_CYC);
    else if (k == sne_pkg::SNE_K_DIE) d = 32'(BE_CYC);
    return d;
  endfunction : dur

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= sne_pkg::ST_IDLE;
      run_er_ff <= 1'b0;
      rem_ff <= 32'h0;
      lat_ff <= 16'h0;
      cur_kind_ff <= 2'h0;
      cur_addr_ff <= 24'h0;
      cur_data_ff <= 8'h0;
      er_susp_ff <= 1'b0;
      pg_susp_ff <= 1'b0;
      er_rem_ff <= 32'h0;
      pg_rem_ff <= 32'h0;
      er_kind_ff <= 2'h0;
      er_addr_ff <= 24'h0;
      pg_addr_ff <= 24'h0;
      pg_data_ff <= 8'h0;
      wel_ff <= 1'b0;
      wip_ff <= 1'b0;
      fsr_ff <= sne_pkg::FSR_RST;
    end else begin
      // Software clear first, so a same-cycle hardware set wins
      if (fsr_clr) begin
        fsr_ff <= fsr_ff & ~(avs_writedata[7:0] & sne_pkg::FSR_W1C);
      end
      if (st_ff != sne_pkg::ST_IDLE) begin
        rem_ff <= rem_ff - 32'h1;
      end
      if (ex && cnt_ff == sne_pkg::CNT_CMD) begin
        if (cmd == sne_pkg::CMD_WREN) begin
          wel_ff <= 1'b1;
        end else if (cmd == sne_pkg::CMD_WRDI) begin
          wel_ff <= 1'b0;
        end else if (cmd == sne_pkg::CMD_SUSPEND
            && st_ff == sne_pkg::ST_RUN) begin
          if (run_er_ff) fsr_ff[sne_pkg::FSR_ER_SUSP] <= 1'b1;
          else fsr_ff[sne_pkg::FSR_PG_SUSP] <= 1'b1;
          // Spare cycle keeps the parked count from reaching zero
          if (rem_ff > 32'(LAT) + 32'h1) begin
            st_ff <= sne_pkg::ST_SUSP;
            lat_ff <= LAT;
          end
        end else if (cmd == sne_pkg::CMD_RESUME
            && st_ff == sne_pkg::ST_IDLE) begin
          if (pg_susp_ff) begin
            pg_susp_ff <= 1'b0;
            fsr_ff[sne_pkg::FSR_PG_SUSP] <= 1'b0;
            st_ff <= sne_pkg::ST_RUN;
            run_er_ff <= 1'b0;
            rem_ff <= pg_rem_ff;
            cur_kind_ff <= sne_pkg::SNE_K_PROG;
            cur_addr_ff <= pg_addr_ff;
            cur_data_ff <= pg_data_ff;
            wip_ff <= 1'b1;
            fsr_ff[sne_pkg::FSR_READY] <= 1'b0;
          end else if (er_susp_ff) begin
            er_susp_ff <= 1'b0;
            fsr_ff[sne_pkg::FSR_ER_SUSP] <= 1'b0;
            st_ff <= sne_pkg::ST_RUN;
            run_er_ff <= 1'b1;
            rem_ff <= er_rem_ff;
            cur_kind_ff <= er_kind_ff;
            cur_addr_ff <= er_addr_ff;
            wip_ff <= 1'b1;
            fsr_ff[sne_pkg::FSR_READY] <= 1'b0;
          end
        end
      end
      if (is_erase && wel_ff && st_ff == sne_pkg::ST_IDLE
          && !er_susp_ff) begin
        if (locked) begin
          fsr_ff[sne_pkg::FSR_PROT] <= 1'b1;
          fsr_ff[sne_pkg::FSR_ER_ERR] <= 1'b1;
        end else begin
          st_ff <= sne_pkg::ST_RUN;
          run_er_ff <= 1'b1;
          rem_ff <= dur(kind);
          cur_kind_ff <= kind;
          cur_addr_ff <= addr;
          wip_ff <= 1'b1;
          fsr_ff[sne_pkg::FSR_READY] <= 1'b0;
        end
      end
      if (is_prog && wel_ff && st_ff == sne_pkg::ST_IDLE
          && !pg_susp_ff) begin
        if (er_susp_ff && addr[23:16] == er_addr_ff[23:16]) begin
          fsr_ff[sne_pkg::FSR_PG_ERR] <= 1'b1;
        end else if (locked) begin
          fsr_ff[sne_pkg::FSR_PROT] <= 1'b1;
          fsr_ff[sne_pkg::FSR_PG_ERR] <= 1'b1;
        end else begin
          st_ff <= sne_pkg::ST_RUN;
          run_er_ff <= 1'b0;
          rem_ff <= dur(sne_pkg::SNE_K_PROG);
          cur_kind_ff <= sne_pkg::SNE_K_PROG;
          cur_addr_ff <= addr;
          cur_data_ff <= pdata;
          wip_ff <= 1'b1;
          fsr_ff[sne_pkg::FSR_READY] <= 1'b0;
        end
      end
      // Latency over: park the remaining work
      if (st_ff == sne_pkg::ST_SUSP) begin
        lat_ff <= lat_ff - 16'h1;
        if (lat_ff == 16'h1) begin
          st_ff <= sne_pkg::ST_IDLE;
          wip_ff <= 1'b0;
          fsr_ff[sne_pkg::FSR_READY] <= 1'b1;
          if (run_er_ff) begin
            er_susp_ff <= 1'b1;
            er_rem_ff <= rem_ff - 32'h1;
            er_kind_ff <= cur_kind_ff;
            er_addr_ff <= cur_addr_ff;
          end else begin
            pg_susp_ff <= 1'b1;
            pg_rem_ff <= rem_ff - 32'h1;
            pg_addr_ff <= cur_addr_ff;
            pg_data_ff <= cur_data_ff;
          end
        end
      end
      if (done_ev && st_ff == sne_pkg::ST_RUN) begin
        st_ff <= sne_pkg::ST_IDLE;
        wip_ff <= 1'b0;
        wel_ff <= 1'b0;
        fsr_ff[sne_pkg::FSR_READY] <= 1'b1;
        if (run_er_ff) fsr_ff[sne_pkg::FSR_ER_SUSP] <= 1'b0;
        else fsr_ff[sne_pkg::FSR_PG_SUSP] <= 1'b0;
        if (!array_verify_ok) begin
          if (run_er_ff) fsr_ff[sne_pkg::FSR_ER_ERR] <= 1'b1;
          else fsr_ff[sne_pkg::FSR_PG_ERR] <= 1'b1;
        end
      end
    end
  end

  // Array strobe at successful completion
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      arr_go <= 1'b0;
      arr_kind <= 2'h0;
      arr_addr <= 24'h0;
      arr_data <= 8'h0;
    end else begin
      arr_go <= done_ev && st_ff == sne_pkg::ST_RUN && array_verify_ok;
      if (done_ev) begin
        arr_kind <= cur_kind_ff;
        arr_addr <= cur_addr_ff;
        arr_data <= run_er_ff ? sne_pkg::ERASE_FILL : cur_data_ff;
      end
    end
  end

  // Read address check against parked operations
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_undefined <= 1'b0;
    end else if (!sel_n_s && cnt_ff == sne_pkg::CNT_ADDR
        && cmd == sne_pkg::CMD_READ) begin
      rd_undefined <= (pg_susp_ff && addr[23:8] == pg_addr_ff[23:8])
        || (er_susp_ff && addr[23:16] == er_addr_ff[23:16]);
    end
  end

  // Avalon slave: one wait cycle, then answer
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      waitreq_ff <= 1'b1;
      avs_readdata <= 32'h0;
      lock_ff <= sne_pkg::LOCK_RST;
    end else begin
      waitreq_ff <= !((avs_read || avs_write) && waitreq_ff);
      if (avs_read && waitreq_ff) begin
        unique case (avs_address)
          sne_pkg::REG_STATUS: avs_readdata <= {28'h0, pg_susp_ff,
            er_susp_ff, wel_ff, wip_ff};
          sne_pkg::REG_FSR: avs_readdata <= {24'h0, fsr_ff};
          sne_pkg::REG_LOCK: avs_readdata <= lock_ff;
          default: avs_readdata <= 32'h0;
        endcase
      end
      if (avs_write && !waitreq_ff && avs_address == sne_pkg::REG_LOCK) begin
        for (int i = 0; i < 4; i++) begin
          if (avs_byteenable[i]) lock_ff[i*8 +: 8] <= avs_writedata[i*8 +: 8];
        end
      end
    end
  end
  assign avs_waitrequest = waitreq_ff;

  property p_busy_flags;
    @(posedge core_clk) disable iff (!nrst)
    st_ff == sne_pkg::ST_RUN |-> wip_ff && !fsr_ff[sne_pkg::FSR_READY];
  endproperty
  a_busy_flags: assert property (p_busy_flags)
    else $error("busy without wip or with ready");

  property p_wel_end;
    @(posedge core_clk) disable iff (!nrst)
    done_ev && st_ff == sne_pkg::ST_RUN |=> !wel_ff && !wip_ff;
  endproperty
  a_wel_end: assert property (p_wel_end)
    else $error("latch or wip not cleared at end");

  property p_no_wel;
    @(posedge core_clk) disable iff (!nrst)
    is_erase && !wel_ff && st_ff == sne_pkg::ST_IDLE
      |=> st_ff == sne_pkg::ST_IDLE && fsr_ff[1] == $past(fsr_ff[1]);
  endproperty
  a_no_wel: assert property (p_no_wel)
    else $error("erase accepted without latch");

  property p_prot;
    @(posedge core_clk) disable iff (!nrst)
    is_erase && wel_ff && st_ff == sne_pkg::ST_IDLE && !er_susp_ff
      && locked |=> fsr_ff[1] && fsr_ff[5] && wel_ff
      && st_ff == sne_pkg::ST_IDLE;
  endproperty
  a_prot: assert property (p_prot)
    else $error("protected erase not refused");

  property p_timeout;
    @(posedge core_clk) disable iff (!nrst)
    done_ev && st_ff == sne_pkg::ST_RUN && run_er_ff && !array_verify_ok
      |=> fsr_ff[sne_pkg::FSR_ER_ERR] && !wel_ff && !arr_go;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("failed erase not flagged");

  property p_susp_lat;
    @(posedge core_clk) disable iff (!nrst)
    $rose(st_ff == sne_pkg::ST_SUSP)
      |-> !fsr_ff[7] ##[1:LAT_A] (fsr_ff[7] && st_ff == sne_pkg::ST_IDLE);
  endproperty
  a_susp_lat: assert property (p_susp_lat)
    else $error("suspend did not settle in latency");

  property p_resume_ign;
    @(posedge core_clk) disable iff (!nrst)
    ex && cnt_ff == sne_pkg::CNT_CMD && cmd == sne_pkg::CMD_RESUME
      && !er_susp_ff && !pg_susp_ff && st_ff == sne_pkg::ST_IDLE
      |=> st_ff == sne_pkg::ST_IDLE && !wip_ff;
  endproperty
  a_resume_ign: assert property (p_resume_ign)
    else $error("resume acted while not suspended");

  property p_prog_drop;
    @(posedge core_clk) disable iff (!nrst)
    is_prog && wel_ff && st_ff == sne_pkg::ST_IDLE && !pg_susp_ff
      && er_susp_ff && addr[23:16] == er_addr_ff[23:16]
      |=> fsr_ff[4] && wel_ff && st_ff == sne_pkg::ST_IDLE;
  endproperty
  a_prog_drop: assert property (p_prog_drop)
    else $error("program into suspended sector ran");

  property p_fill;
    @(posedge core_clk) disable iff (!nrst)
    arr_go && arr_kind != sne_pkg::SNE_K_PROG |-> arr_data == 8'hff;
  endproperty
  a_fill: assert property (p_fill)
    else $error("erase fill not FFh");

  property p_bus;
    @(posedge core_clk) disable iff (!nrst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_bus: assert property (p_bus)
    else $error("waitrequest held too long");
endmodule : sne_erase_seq
`default_nettype wire

// [sim/sne_host_model.sv]
// Host-side serial command model for the erase sequencer
`timescale 1ns/1ps
`default_nettype none
module sne_host_model (
  // Clock
  input wire logic core_clk,
  // Serial pins
  output logic sck,
  output logic select_n,
  output logic serial_data_lines
);
  initial begin
    sck = 1'b0;
    select_n = 1'b1;
    serial_data_lines = 1'b0;
  end
  // Whole bytes MSB first; drop trims trailing bits for abort tests
  task automatic frame(input logic [7:0] b[$], input int drop);
    int n;
    n = 8 * b.size() - drop;
    @(posedge core_clk);
    select_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      serial_data_lines <= b[i / 8][7 - i % 8];
      repeat (4) @(posedge core_clk);
      sck <= 1'b1;
      repeat (4) @(posedge core_clk);
      sck <= 1'b0;
    end
    repeat (4) @(posedge core_clk);
    select_n <= 1'b1;
    // Released line must not keep its last value
    serial_data_lines <= ~serial_data_lines;
    repeat (8) @(posedge core_clk);
  endtask : frame
endmodule : sne_host_model
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench for the erase and suspend sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int SSE = 600;
  localparam int SE = 800;
  localparam int BE = 1000;
  logic core_clk, nrst, sck, select_n, serial_data_lines, array_verify_ok;
  logic arr_go, rd_undefined, avs_read, avs_write, avs_waitrequest;
  logic [1:0] arr_kind, go_kind;
  logic [23:0] arr_addr, go_addr, a, b;
  logic [7:0] arr_data, go_data, pd;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata;
  logic [7:0] op [3];
  int fails = 0, check_count = 0, cyc = 0, go_cnt = 0, go_t, seed, n0, t0;

  sne_erase_seq #(.SSE_CYC(SSE), .SE_CYC(SE), .BE_CYC(BE), .PP_CYC(700))
    i_sne_erase_seq (.core_clk, .nrst, .sck, .select_n, .serial_data_lines,
    .array_verify_ok, .arr_go, .arr_kind, .arr_addr, .arr_data,
    .rd_undefined, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest);
  sne_host_model i_sne_host_model (.core_clk, .sck, .select_n,
    .serial_data_lines);

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (arr_go === 1'b1) begin
      go_cnt <= go_cnt + 1;
      go_t <= cyc;
      go_kind <= arr_kind;
      go_addr <= arr_addr;
      go_data <= arr_data;
    end
    if (cyc == 40000) begin
      fails++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // One Avalon transfer, held until waitrequest is seen low
  task automatic av(input logic w, input logic [3:0] ad,
      input logic [31:0] wd, output logic [31:0] d);
    @(posedge core_clk);
    avs_address <= ad;
    avs_writedata <= wd;
    avs_read <= ~w;
    avs_write <= w;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : av

  task automatic wr(input logic [3:0] ad, input logic [31:0] wd);
    logic [31:0] d;
    av(1'b1, ad, wd, d);
  endtask : wr

  task automatic rdc(input logic [3:0] ad, input logic [31:0] e,
      input logic [31:0] m = 32'hffffffff);
    logic [31:0] d;
    av(1'b0, ad, 32'h0, d);
    chk(ad == 4'h4 ? "fsr" : ad == 4'h0 ? "status" : "reg", d & m, e);
  endtask : rdc

  task automatic cmd(input logic [7:0] c);
    i_sne_host_model.frame({c}, 0);
  endtask : cmd

  task automatic ers(input logic [7:0] c, input logic [23:0] ad,
      input int drop);
    i_sne_host_model.frame({c, ad[23:16], ad[15:8], ad[7:0]}, drop);
  endtask : ers

  task automatic wait_go(input int n);
    for (int k = 0; k < 2000 && go_cnt == n; k++) @(posedge core_clk);
    chk("completions", go_cnt, n + 1);
  endtask : wait_go

  function automatic logic [31:0] fsr(input logic r, es, ee, pe, ps, pr);
    fsr = 32'h0;
    fsr[sne_pkg::FSR_READY] = r;
    fsr[sne_pkg::FSR_ER_SUSP] = es;
    fsr[sne_pkg::FSR_ER_ERR] = ee;
    fsr[sne_pkg::FSR_PG_ERR] = pe;
    fsr[sne_pkg::FSR_PG_SUSP] = ps;
    fsr[sne_pkg::FSR_PROT] = pr;
  endfunction : fsr

  function automatic int dur(input int k);
    dur = k == 0 ? SSE : k == 1 ? SE : BE;
  endfunction : dur

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  initial begin
    seed = 32'h0b64cdba;
    op = '{sne_pkg::CMD_SUB_ERASE, sne_pkg::CMD_SEC_ERASE,
      sne_pkg::CMD_DIE_ERASE};
    nrst = 1'b0;
    array_verify_ok = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    rdc(4'h4, fsr(1, 0, 0, 0, 0, 0));
    rdc(4'h0, 32'h0);
    rdc(4'hc, 32'h0);
    $display("done: reset");
    for (int k = 0; k < 3; k++) begin
      a = 24'($random(seed));
      ers(op[k], a, 0);
      rdc(4'h0, 32'h0);
      cmd(sne_pkg::CMD_WREN);
      n0 = go_cnt;
      ers(op[k], a, 0);
      t0 = cyc;
      rdc(4'h0, 32'h3);
      rdc(4'h4, fsr(0, 0, 0, 0, 0, 0));
      wait_go(n0);
      chk("kind", 32'(go_kind), 32'(k));
      chk("fill", 32'(go_data), 32'(sne_pkg::ERASE_FILL));
      if (k < 2) chk("addr", 32'(go_addr), 32'(a));
      chk("time", 32'(go_t - t0 + 20 > dur(k) && go_t - t0 < dur(k) + 20),
        32'h1);
      rdc(4'h0, 32'h0);
      rdc(4'h4, fsr(1, 0, 0, 0, 0, 0));
    end
    $display("done: erase kinds");
    cmd(sne_pkg::CMD_WREN);
    ers(sne_pkg::CMD_SEC_ERASE, a, 1);
    rdc(4'h0, 32'h2);
    rdc(4'h4, fsr(1, 0, 0, 0, 0, 0));
    wr(4'h8, 32'h1 << a[20:16]);
    ers(sne_pkg::CMD_SUB_ERASE, a, 0);
    rdc(4'h0, 32'h2);
    rdc(4'h4, fsr(1, 0, 1, 0, 0, 1));
    wr(4'h4, 32'(sne_pkg::FSR_W1C));
    ers(sne_pkg::CMD_DIE_ERASE, 24'h0, 0);
    rdc(4'h0, 32'h2);
    rdc(4'h4, fsr(1, 0, 1, 0, 0, 1));
    wr(4'h4, 32'(sne_pkg::FSR_W1C));
    wr(4'h8, 32'h0);
    $display("done: refusals");
    cmd(sne_pkg::CMD_WRDI);
    ers(sne_pkg::CMD_SUB_ERASE, a, 0);
    rdc(4'h0, 32'h0);
    cmd(sne_pkg::CMD_WREN);
    array_verify_ok <= 1'b0;
    n0 = go_cnt;
    ers(sne_pkg::CMD_SUB_ERASE, a, 0);
    repeat (SSE + 20) @(posedge core_clk);
    chk("no completion", go_cnt, n0);
    rdc(4'h0, 32'h0);
    rdc(4'h4, fsr(1, 0, 1, 0, 0, 0));
    array_verify_ok <= 1'b1;
    wr(4'h4, 32'(sne_pkg::FSR_W1C));
    $display("done: timeout");
    a = 24'($random(seed));
    b = a ^ 24'h010000;
    pd = 8'($random(seed));
    cmd(sne_pkg::CMD_WREN);
    ers(sne_pkg::CMD_SEC_ERASE, a, 0);
    cmd(sne_pkg::CMD_SUSPEND);
    rdc(4'h4, fsr(0, 1, 0, 0, 0, 0));
    repeat (sne_pkg::SUSP_LAT_CYC) @(posedge core_clk);
    rdc(4'h4, fsr(1, 1, 0, 0, 0, 0));
    rdc(4'h0, 32'h4, 32'hd);
    cmd(sne_pkg::CMD_WREN);
    i_sne_host_model.frame({sne_pkg::CMD_PROG, a[23:16], a[15:8], a[7:0], pd},
      0);
    rdc(4'h4, fsr(1, 1, 0, 1, 0, 0));
    rdc(4'h0, 32'h6, 32'hf);
    wr(4'h4, 32'(sne_pkg::FSR_W1C));
    ers(sne_pkg::CMD_READ, a, 0);
    chk("undef", 32'(rd_undefined), 32'h1);
    ers(sne_pkg::CMD_READ, b, 0);
    chk("undef", 32'(rd_undefined), 32'h0);
    i_sne_host_model.frame({sne_pkg::CMD_PROG, b[23:16], b[15:8], b[7:0], pd},
      0);
    cmd(sne_pkg::CMD_SUSPEND);
    repeat (sne_pkg::SUSP_LAT_CYC) @(posedge core_clk);
    rdc(4'h4, fsr(1, 1, 0, 0, 1, 0));
    ers(sne_pkg::CMD_READ, b, 0);
    chk("undef", 32'(rd_undefined), 32'h1);
    wr(4'h8, 32'h1 << a[20:16]);
    n0 = go_cnt;
    cmd(sne_pkg::CMD_RESUME);
    rdc(4'h0, 32'h5, 32'hd);
    rdc(4'h4, fsr(0, 1, 0, 0, 0, 0));
    wait_go(n0);
    chk("kind", 32'(go_kind), 32'h3);
    chk("data", 32'(go_data), 32'(pd));
    cmd(sne_pkg::CMD_RESUME);
    wait_go(n0 + 1);
    chk("kind", 32'(go_kind), 32'h1);
    cmd(sne_pkg::CMD_RESUME);
    rdc(4'h0, 32'h0, 32'hd);
    rdc(4'h4, fsr(1, 0, 0, 0, 0, 0));
    wr(4'h8, 32'h0);
    $display("done: nested suspend");
    cmd(sne_pkg::CMD_WREN);
    n0 = go_cnt;
    ers(sne_pkg::CMD_SUB_ERASE, a, 0);
    repeat (SSE - 300) @(posedge core_clk);
    cmd(sne_pkg::CMD_SUSPEND);
    rdc(4'h4, fsr(0, 1, 0, 0, 0, 0));
    wait_go(n0);
    rdc(4'h4, fsr(1, 0, 0, 0, 0, 0));
    $display("done: late suspend");
    cmd(sne_pkg::CMD_WREN);
    ers(sne_pkg::CMD_SEC_ERASE, b, 0);
    cmd(sne_pkg::CMD_SUSPEND);
    repeat (sne_pkg::SUSP_LAT_CYC) @(posedge core_clk);
    rdc(4'h0, 32'h4, 32'hd);
    // Power loss while suspended: nothing of the suspend survives
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    rdc(4'h4, fsr(1, 0, 0, 0, 0, 0));
    cmd(sne_pkg::CMD_RESUME);
    rdc(4'h0, 32'h0);
    $display("done: power loss");
    conclude();
  end
endmodule : tb_top
`default_nettype wire
